// file: hmseq_core.sv
`timescale 1ns/1ps

// Contract
// - Method 14: negative high, slow on home, index stop
// - Method 14 decel: negative low, index after fall
// - Method 14 negative limit: reverse, index slows back
// - Codes 15 and 16 are reserved, refused
// - Methods 17-30 stop on switch edge instead; only 23, 24, 25 and 30 run here, the rest are refused
// - Method 23 limit: reverse, slow on home, stop fall
// - Method 24: positive high, turn twice, stop home rise
// - Method 24 decel: negative low, turn, stop rise
// - Method 24 limit: index rise slow, fall turns
// - Method 25: positive high, slow, turn, stop rise
// - Method 25 decel: positive low, turn, stop rise
// - Positive limit before home reverses at high speed
module hmseq_core
    import hmseq_pkg::*;
#(
    parameter int POS_W = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             start,
    input  wire logic [7:0]       method,
    input  wire hmseq_pins_t      pins,
    input  wire logic [POS_W-1:0] position,
    output hmseq_cmd_t            cmd,
    output logic                  busy,
    output logic                  done,
    output logic                  refused,
    output logic                  refused_reserved,
    output logic [POS_W-1:0]      home_pos
);

    // ************************************************************
    // Method decode
    // ************************************************************
    function automatic hmseq_cls_t decode_method(input logic [7:0] code);
        hmseq_cls_t c;
        c = C_NONE;
        unique case (code)
            METHOD_14: c = C_M14;
            METHOD_30: c = C_M30;
            METHOD_23: c = C_M23;
            METHOD_24: c = C_M24;
            METHOD_25: c = C_M25;
            default:   c = C_NONE;
        endcase
        return c;
    endfunction

    function automatic logic is_reserved(input logic [7:0] code);
        return (code == METHOD_RSV_LO) || (code == METHOD_RSV_HI);
    endfunction

    // ************************************************************
    // Pin synchronisers and edge detect
    // ************************************************************
    hmseq_pins_t  pin_meta;
    hmseq_pins_t  pin_sync;
    hmseq_pins_t  pin_prev;
    hmseq_pins_t  rise;
    hmseq_pins_t  fall;

    // Two stages before use; the first stage feeds only the second
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end else begin
            pin_meta <= pins;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign rise = pin_sync & ~pin_prev;
    assign fall = ~pin_sync & pin_prev;

    // ************************************************************
    // Sequencer
    // ************************************************************
    hmseq_state_t state;
    hmseq_state_t next_state;
    hmseq_cls_t   cls;
    hmseq_cls_t   start_cls;
    hmseq_cls_t   c;
    hmseq_cmd_t   next_cmd;
    logic         decel_run;
    logic         start_ok;
    logic         lim_hit;
    logic         adv;
    logic         stop;

    assign busy      = (state != S_IDLE);
    assign start_cls = decode_method(method);
    assign start_ok  = start && !busy && (start_cls != C_NONE);
    assign c         = busy ? cls : start_cls;
    // Only the limit in the starting direction counts, and only before home
    assign lim_hit   = (c == C_M14 || c == C_M30) ? pin_sync.neg_lim : pin_sync.pos_lim;

    // Transition table; one move per qualifying edge
    always_comb begin
        next_state = state;
        next_cmd   = cmd;
        stop       = 1'b0;
        adv        = 1'b0;
        unique case (state)
            S_IDLE: begin
                if (start_ok && pin_sync.decel) begin
                    next_state     = S_SLOW1;
                    next_cmd.dir   = (c == C_M25) ? DIR_POS : DIR_NEG;
                    next_cmd.speed = SPD_LOW;
                end else if (start_ok) begin
                    next_state     = S_FAST;
                    next_cmd.dir   = (c == C_M14 || c == C_M30) ? DIR_NEG : DIR_POS;
                    next_cmd.speed = SPD_HIGH;
                end
            end
            S_FAST: begin
                if (lim_hit) begin
                    next_state     = S_REV;
                    next_cmd.dir   = ~cmd.dir;
                    next_cmd.speed = SPD_HIGH;
                end else if (rise.home) begin
                    next_state     = S_SLOW1;
                    next_cmd.dir   = (c == C_M25) ? DIR_POS : DIR_NEG;
                    next_cmd.speed = SPD_LOW;
                end
            end
            S_REV: begin
                // Method 23 waits for home, the others for the index
                if ((c == C_M23) ? rise.home : rise.index) begin
                    next_state     = S_SLOW1;
                    next_cmd.dir   = DIR_NEG;
                    next_cmd.speed = SPD_LOW;
                end
            end
            S_SLOW1: begin
                adv = ((c == C_M24 || c == C_M25) && !decel_run) ? fall.index : fall.home;
                if (adv && (c == C_M30 || c == C_M23)) begin
                    stop = 1'b1;
                end else if (adv) begin
                    next_state     = S_SLOW2;
                    next_cmd.dir   = (c == C_M24) ? DIR_POS : DIR_NEG;
                    next_cmd.speed = SPD_LOW;
                end
            end
            S_SLOW2: begin
                // Method 14 still takes its reference from the index
                stop = (c == C_M14) ? rise.index : rise.home;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (stop) begin
            next_state     = S_IDLE;
            next_cmd.speed = SPD_ZERO;
        end
    end

    // State and motion command
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            cmd   <= '{dir: DIR_NEG, speed: SPD_ZERO};
        end else begin
            state <= next_state;
            cmd   <= next_cmd;
        end
    end

    // Family and start condition are frozen for the whole run
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cls       <= C_NONE;
            decel_run <= 1'b0;
        end else if (start_ok) begin
            cls       <= start_cls;
            decel_run <= pin_sync.decel;
        end
    end

    // Completion and reference capture
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done     <= 1'b0;
            home_pos <= '0;
        end else begin
            done <= stop;
            if (stop) begin
                home_pos <= position;
            end
        end
    end

    // Refusal of codes with no sequence here; start while busy is ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            refused          <= 1'b0;
            refused_reserved <= 1'b0;
        end else begin
            refused          <= start && !busy && (start_cls == C_NONE);
            refused_reserved <= start && !busy && is_reserved(method);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_m14_index_stop;
        state == S_SLOW2 && cls == C_M14 && rise.index;
    endsequence

    sequence s_stop_pulse;
        done && cmd.speed == SPD_ZERO && state == S_IDLE ##1 !done;
    endsequence

    a_m14_index_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_m14_index_stop |=> s_stop_pulse)
        else $error("method 14 did not stop on index");

    a_m14_decel: assert property (@(posedge sys_clk) disable iff (sys_rst)
        start_ok && start_cls == C_M14 && pin_sync.decel
        |=> state == S_SLOW1 && cmd.dir == DIR_NEG && cmd.speed == SPD_LOW)
        else $error("method 14 decel start wrong");

    a_neg_reverse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_FAST && cls == C_M14 && pin_sync.neg_lim
        |=> state == S_REV && cmd.dir == DIR_POS && cmd.speed == SPD_HIGH)
        else $error("negative limit did not reverse");

    a_reserved_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
        start && !busy && is_reserved(method) |=> refused && refused_reserved && !busy)
        else $error("reserved code not refused");

    a_m30_switch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_SLOW1 && cls == C_M30 && fall.home |=> done)
        else $error("method 30 did not stop on home fall");

    a_m23_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_SLOW1 && cls == C_M23 && fall.home |=> done && state == S_IDLE)
        else $error("method 23 did not stop");

    a_m24_turn: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_SLOW1 && cls == C_M24 && !decel_run && fall.index
        |=> cmd.dir == DIR_POS && cmd.speed == SPD_LOW)
        else $error("method 24 index turn wrong");

    a_m24_decel: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_SLOW1 && cls == C_M24 && decel_run && fall.home
        |=> state == S_SLOW2 && cmd.dir == DIR_POS)
        else $error("method 24 decel turn wrong");

    a_m24_rev_index: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_REV && cls == C_M24 && rise.index
        |=> cmd.dir == DIR_NEG && cmd.speed == SPD_LOW)
        else $error("method 24 reversed index slow wrong");

    a_m25_home: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_FAST && cls == C_M25 && !pin_sync.pos_lim && rise.home
        |=> cmd.dir == DIR_POS && cmd.speed == SPD_LOW)
        else $error("method 25 home slow wrong");

    a_m25_decel: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_SLOW1 && cls == C_M25 && decel_run && fall.home
        |=> cmd.dir == DIR_NEG && cmd.speed == SPD_LOW)
        else $error("method 25 decel turn wrong");

    a_pos_reverse: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_FAST && (cls == C_M24 || cls == C_M25) && pin_sync.pos_lim
        |=> state == S_REV && cmd.dir == DIR_NEG && cmd.speed == SPD_HIGH)
        else $error("positive limit did not reverse");

    a_pin_latency: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state == S_FAST && cls == C_M24 && !pins.pos_lim && !pins.home
        ##1 (pins.home && !pins.pos_lim) [*3] ##0 state == S_FAST
        |=> state == S_SLOW1)
        else $error("home edge not acted on after sync");

    a_idle_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        done |-> home_pos == $past(position) && $past(busy) && cmd.speed == SPD_ZERO)
        else $error("stop did not latch position");

endmodule

// file: hmseq_pkg.sv
package hmseq_pkg;

    // ************************************************************
    // Method codes
    // ************************************************************
    localparam logic [7:0] METHOD_14     = 8'h0E;
    localparam logic [7:0] METHOD_RSV_LO = 8'h0F;
    localparam logic [7:0] METHOD_RSV_HI = 8'h10;
    localparam logic [7:0] METHOD_23     = 8'h17;
    localparam logic [7:0] METHOD_24     = 8'h18;
    localparam logic [7:0] METHOD_25     = 8'h19;
    localparam logic [7:0] METHOD_30     = 8'h1E;

    // ************************************************************
    // Motion encodings
    // ************************************************************
    localparam logic DIR_POS = 1'b1;
    localparam logic DIR_NEG = 1'b0;

    typedef enum logic [1:0] {
        SPD_ZERO = 2'h0,
        SPD_LOW  = 2'h1,
        SPD_HIGH = 2'h2
    } hmseq_speed_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_FAST  = 3'h1,
        S_REV   = 3'h2,
        S_SLOW1 = 3'h3,
        S_SLOW2 = 3'h4
    } hmseq_state_t;

    // Sequence family; C_NONE marks a code this block cannot run
    typedef enum logic [2:0] {
        C_NONE = 3'h0,
        C_M14  = 3'h1,
        C_M30  = 3'h2,
        C_M23  = 3'h3,
        C_M24  = 3'h4,
        C_M25  = 3'h5
    } hmseq_cls_t;

    // Switch and encoder pins, also used for their edge vectors
    typedef struct packed {
        logic home;
        logic neg_lim;
        logic pos_lim;
        logic index;
        logic decel;
    } hmseq_pins_t;

    typedef struct packed {
        logic         dir;
        hmseq_speed_t speed;
    } hmseq_cmd_t;

endpackage

// file: hmseq_sw_model.sv
`timescale 1ns/1ps

// ************************************************************
// Home switch, limit switches and encoder index
// ************************************************************
module hmseq_sw_model
    import hmseq_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire hmseq_cmd_t cmd,
    output hmseq_pins_t     pins,
    output logic [31:0]     position
);
    // Pin levels, set by the bench between edges; clean levels, no bounce
    hmseq_pins_t lv;

    initial lv = '0;
    assign pins = lv;

    // Axis travel follows the command and halts at speed zero, so the latched reference holds still
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            position <= 32'h0000_1000;
        end else if (cmd.speed != SPD_ZERO) begin
            if (cmd.dir == DIR_POS) begin
                position <= position + ((cmd.speed == SPD_HIGH) ? 32'h4 : 32'h1);
            end else begin
                position <= position - ((cmd.speed == SPD_HIGH) ? 32'h4 : 32'h1);
            end
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/1ps

module testbench;
    import hmseq_pkg::*;

    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        start   = 1'b0;
    logic [7:0]  method  = 8'h00;
    hmseq_pins_t pins;
    hmseq_cmd_t  cmd;
    logic        busy, done, refused, refused_reserved, done_q;
    logic [31:0] position, home_pos, pos_q;
    logic [2:0]  cm;
    logic [2:0]  last = 3'h0;
    logic [19:0] word = 20'h00000;
    logic [7:0]  bad [8] = '{8'h00, 8'h01, 8'h0D, 8'h0F, 8'h10, 8'h11, 8'h1A, 8'hFF};
    logic [7:0]  good [5] = '{METHOD_14, METHOD_30, METHOD_23, METHOD_24, METHOD_25};
    integer      seed = 32'h810ce852;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          n_done = 0;

    always #4 sys_clk = ~sys_clk;

    hmseq_core #(.POS_W(32)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start),
        .method(method), .pins(pins), .position(position), .cmd(cmd), .busy(busy),
        .done(done), .refused(refused), .refused_reserved(refused_reserved),
        .home_pos(home_pos));
    hmseq_sw_model sw (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd), .pins(pins),
        .position(position));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: saw %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Random spacing keeps every edge well apart from the previous reaction
    task automatic edge_pin(input int p, input logic val);
        tick(8 + ($random(seed) & 7));
        if (p == 0) sw.lv.home = val;
        else sw.lv.index = val;
    endtask

    // Commands in order, one nibble each, stop as zero; v: 0 plain, 1 decel, 2 limit
    function automatic logic [19:0] exp_traj(input logic [7:0] m, input int v);
        case (m)
            METHOD_23: return (v == 0) ? 20'h00610 : (v == 1) ? 20'h00010 : 20'h06210;
            METHOD_24: return (v == 0) ? 20'h06150 : (v == 1) ? 20'h00150 : 20'h62150;
            METHOD_25: return (v == 0) ? 20'h06510 : (v == 1) ? 20'h00510 : 20'h06210;
            default:   return (v == 0) ? 20'h00210 : (v == 1) ? 20'h00010 : 20'h02610;
        endcase
    endfunction

    // Speed zero masks the direction, so a stop logs as a single zero
    assign cm = (cmd.speed == SPD_ZERO) ? 3'h0 : cmd;

    // Trajectory log and stop checks, all on values held before this edge
    always @(posedge sys_clk) begin
        pos_q <= position;
        done_q <= done;
        if (cm !== last) begin
            word <= {word[15:0], 1'b0, cm};
            last <= cm;
        end
        if (done === 1'b1) begin
            n_done++;
            chk(home_pos, pos_q, "home_pos latch");
            chk(done_q, 1'b0, "done width");
            chk(busy, 1'b0, "busy at stop");
        end
    end

    task automatic run(input logic [7:0] m, input int v);
        logic neg_first;
        int   d0;
        neg_first = (m == METHOD_14) || (m == METHOD_30);
        d0 = n_done;
        word = 20'h00000;
        sw.lv.decel = (v == 1);
        tick(4);
        method = m;
        start = 1'b1;
        tick(1);
        chk(busy, 1'b1, "busy after start");
        method = METHOD_RSV_LO;
        tick(1);
        start = 1'b0;
        tick(1);
        chk(refused, 1'b0, "start while busy");
        chk(refused_reserved, 1'b0, "reserved while busy");
        // Limit run uses the start-direction limit; plain run shows the other one as a decoy
        if (v != 1) begin
            tick(6);
            if (neg_first == (v == 2)) sw.lv.neg_lim = 1'b1;
            else sw.lv.pos_lim = 1'b1;
            tick(6);
            sw.lv.neg_lim = 1'b0;
            sw.lv.pos_lim = 1'b0;
        end
        // One fixed edge train serves every method; edges a step does not want are ignored
        for (int k = 0; k < 8; k++) begin
            if (k[0]) begin
                edge_pin(0, !sw.lv.home);
            end else begin
                edge_pin(1, 1'b1);
                edge_pin(1, 1'b0);
            end
        end
        tick(4);
        chk(word, exp_traj(m, v), "path");
        chk(n_done - d0, 1, "one stop");
        sw.lv.decel = 1'b0;
        $display("test method %0d variant %0d ended", m, v);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(16);
        sys_rst = 1'b0;
        chk({cmd, busy, done, refused}, 6'h00, "reset outputs");
        chk(home_pos, 32'h0, "reset home_pos");
        for (int i = 0; i < 9; i++) begin
            method = (i < 8) ? bad[i] : 8'h1F + 8'($random(seed) & 8'h3F);
            start = 1'b1;
            tick(1);
            start = 1'b0;
            chk(busy, 1'b0, "no run");
            chk(refused, 1'b1, "refused");
            chk(refused_reserved, (method == 8'h0F) || (method == 8'h10), "reserved");
            tick(1);
            chk(refused, 1'b0, "refused width");
        end
        $display("test refusals ended");
        for (int i = 0; i < 5; i++) begin
            for (int v = 0; v < 3; v++) run(good[i], v);
        end
        method = METHOD_24;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(10);
        sys_rst = 1'b1;
        tick(2);
        chk({cmd, busy}, 4'h0, "reset mid-run");
        sys_rst = 1'b0;
        // Outputs must stay quiet past release, then a full run must still work
        tick(1);
        chk({cmd, busy, done, refused}, 6'h00, "after release");
        run(METHOD_14, 0);
        $display("test mid-run reset ended");
        conclude();
    end
endmodule
